// *** include/dio_params.svh ***
// Purpose : constants for the digital i/o, totalizer and setpoint block
// Assumes : one 125 MHz clock, 32-bit register bus with word registers
// Notes   : register index = byte address / 4; channel numbers double as indices
`ifndef DIO_PARAMS_SVH
`define DIO_PARAMS_SVH

// ==================================================================
// widths
`define PORT_W        8
`define COUNT_W       26
`define DAC_W         16
`define IDX_W         6
`define BCD_W         12

// ==================================================================
// register indices (byte address is four times these)
`define IDX_CTRL      6'h00
`define IDX_PORT0     6'h01
`define IDX_PORT1     6'h02
`define IDX_COUNT     6'h03
`define IDX_DAC0      6'h04
`define IDX_DAC1      6'h05
`define IDX_RESET     6'h06
`define IDX_DIR       6'h07

// ==================================================================
// control register fields
`define CTRL_BASE0    0
`define CTRL_BASE1    1
`define CTRL_MODE     2
`define CTRL_EDGE     3
`define CTRL_W        4
`define CTRL_RST      4'h0

// ==================================================================
// reset values and misc
`define DIR_RST       2'h0
`define DAC_ZERO      16'h0000
`define PORT_RST      8'h00
`define CHAN_W        3

`endif

// *** include/dio_pkg.sv ***
// Purpose : shared types of the digital i/o and totalizer block
// Assumes : dio_params.svh is on the include path
// Notes   : numbers live in the header, types live here
`default_nettype none
`include "dio_params.svh"

package dio_pkg;
   typedef logic [`PORT_W-1:0]         port_t;   // one 8-bit port
   typedef logic [`COUNT_W-1:0]        count_t;  // totalizer count
   typedef logic signed [`DAC_W-1:0]   dac_t;    // signed setpoint code
   typedef logic [`IDX_W-1:0]          idx_t;    // register index
endpackage

`default_nettype wire

// *** include/count_if.sv ***
// Purpose : links the register logic to the totalizer core
// Assumes : both ends on clk
// Notes   : clear is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none

interface count_if;
   import dio_pkg::*;
   logic   edge_fall;  // 1 counts falling edges
   logic   clr;        // one-cycle clear request
   count_t count;      // running count, from a flop

   modport ctrl    (output edge_fall, output clr, input count);
   modport counter (input edge_fall, input clr, output count);
endinterface

`default_nettype wire

// *** src/pulse_counter.sv ***
// Purpose : 26-bit pulse totalizer with edge select and clear
// Assumes : pulse source is asynchronous and below 100 kHz
// Notes   : wraps to zero past the top; a clear never loses an edge
`timescale 1ns/100ps
`default_nettype none
`include "dio_params.svh"

module pulse_counter
   import dio_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic pulse_in,
   count_if.counter  cnt
);
   // ==================================================================
   // input synchroniser and edge detect
   logic   sync1_reg;  // first stage, read only by sync2
   logic   sync2_reg;  // safe level
   logic   prev_reg;   // level one cycle older
   logic   hit;        // qualifying edge this cycle
   count_t count_reg;

   // two flops before any logic sees the pin
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg  <= 1'b0;
      end
      else
      begin
         sync1_reg <= pulse_in;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   // edge select: falling or rising
   assign hit = cnt.edge_fall ? (prev_reg & ~sync2_reg)
                              : (~prev_reg & sync2_reg);

   // ==================================================================
   // count: runs from reset with no enable; an edge during a clear is kept
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         count_reg <= '0;
      else if (cnt.clr)
         count_reg <= {{(`COUNT_W-1){1'b0}}, hit};
      else
         count_reg <= count_reg + {{(`COUNT_W-1){1'b0}}, hit};
   end

   assign cnt.count = count_reg;

   // ==================================================================
   // checks
   count_step_a : assert property (@(posedge clk) disable iff (!rst_b)
      hit && !cnt.clr |=> count_reg == $past(count_reg) + 26'h0000001)
      else $error("count did not step on an edge");

   count_wrap_a : assert property (@(posedge clk) disable iff (!rst_b)
      hit && !cnt.clr && (&count_reg) |=> count_reg == '0)
      else $error("count did not wrap to zero");

   count_clear_a : assert property (@(posedge clk) disable iff (!rst_b)
      cnt.clr |=> count_reg == {{(`COUNT_W-1){1'b0}}, $past(hit)})
      else $error("clear lost an edge or left a count");
endmodule

`default_nettype wire

// *** src/dio_totalizer.sv ***
// Purpose : two 8-bit i/o ports, pulse totalizer and two setpoint channels
// Assumes : AHB-Lite slave, single word transfers, one 125 MHz clock
// Notes   : zero wait states; read data is taken at the address phase edge
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.

`timescale 1ns/100ps
`default_nettype none
`include "dio_params.svh"

module dio_totalizer
   import dio_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire logic [1:0][7:0]     dio_in,
   output logic      [1:0][7:0]     dio_out,
   output logic      [1:0][7:0]     dio_oe,
   input  wire logic                pulse_in,
   output logic      [15:0]         dac0_code,
   output logic      [15:0]         dac1_code
);

   // ==================================================================
   // number base helpers
   // binary to three bcd digits (double dabble)
   function automatic logic [`BCD_W-1:0] bin_to_bcd(input port_t v);
      logic [`BCD_W+`PORT_W-1:0] sh;
      sh = {{`BCD_W{1'b0}}, v};
      for (int i = 0; i < `PORT_W; i++)
      begin
         if (sh[11:8] > 4'h4)
            sh[11:8] = sh[11:8] + 4'h3;
         if (sh[15:12] > 4'h4)
            sh[15:12] = sh[15:12] + 4'h3;
         if (sh[19:16] > 4'h4)
            sh[19:16] = sh[19:16] + 4'h3;
         sh = {sh[`BCD_W+`PORT_W-2:0], 1'b0};
      end
      return sh[`BCD_W+`PORT_W-1:`PORT_W];
   endfunction

   // three bcd digits to binary; values past 255 keep the low 8 bits
   function automatic port_t bcd_to_bin(input logic [`BCD_W-1:0] b);
      logic [9:0] s;
      s = 10'(b[11:8]) * 10'h064 + 10'(b[7:4]) * 10'h00a + 10'(b[3:0]);
      return s[`PORT_W-1:0];
   endfunction

   // ==================================================================
   // declarations
   logic [`CTRL_W-1:0] ctrl_reg;      // base bits, count mode, edge select
   logic [1:0]         dir_reg;       // 1 = port drives its pins
   port_t [1:0]        pat_reg;       // latched output patterns
   port_t [1:0]        sync1_reg;     // pin sync stage one
   port_t [1:0]        pin_reg;       // pin sync stage two, live levels
   logic [31:0]        rdata_reg;     // read data for the data phase
   logic               ready_reg;     // hreadyout
   logic               wr_reg;        // a write data phase is pending
   idx_t               widx_reg;      // its register index
   logic [15:0]        dac_reg [2];   // setpoint codes
   logic               clr_now;       // counter clear, same edge as capture
   logic               addr_ok;       // valid address phase this cycle
   idx_t               aidx;          // index of that phase
   logic               scan_count_read_step; // counter read this cycle
   logic               rst_cmd;       // write to the reset register
   logic [`CHAN_W-1:0] rst_chan;      // channel named by that write
   logic [31:0]        rd_mux;        // read data being selected
   count_if            cnt ();

   // ==================================================================
   // bus decode
   // a transfer counts only when selected, NONSEQ/SEQ and the bus ready
   assign addr_ok  = hsel & htrans[1] & hready;
   assign aidx     = haddr[`IDX_W+1:2];
   assign scan_count_read_step = addr_ok & ~hwrite & (aidx == `IDX_COUNT);
   assign rst_cmd  = wr_reg & (widx_reg == `IDX_RESET);
   assign rst_chan = hwdata[`CHAN_W-1:0];

   // data phase bookkeeping for writes
   // a write lands one edge later, once hwdata stands in the data phase
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_reg   <= 1'b0;
         widx_reg <= '0;
      end
      else
      begin
         wr_reg   <= addr_ok & hwrite;
         widx_reg <= aidx;
      end
   end

   // never stalls, never errors; flopped so outputs stay registered
   // the flop also keeps hreadyout low for as long as reset is held
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ready_reg <= 1'b0;
      end
      else
      begin
         ready_reg <= 1'b1;
      end
   end

   // ==================================================================
   // control register: base per port, count mode, edge
   // one word holds all four settings; upper write bits are dropped
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         ctrl_reg <= `CTRL_RST;
      else if (wr_reg && widx_reg == `IDX_CTRL)
         ctrl_reg <= hwdata[`CTRL_W-1:0];
   end

   assign cnt.edge_fall = ctrl_reg[`CTRL_EDGE];

   // ==================================================================
   // digital ports: sync, pattern latch, direction (one loop per port)
   for (genvar p = 0; p < 2; p++)
   begin : g_port
      // pins pass two flops before being read
      always_ff @(posedge clk or negedge rst_b)
      begin
         if (!rst_b)
         begin
            sync1_reg[p] <= `PORT_RST;
            pin_reg[p]   <= `PORT_RST;
         end
         else
         begin
            sync1_reg[p] <= dio_in[p];
            pin_reg[p]   <= sync1_reg[p];
         end
      end

      // the pattern is held until the next write to the same channel
      always_ff @(posedge clk or negedge rst_b)
      begin
         if (!rst_b)
            pat_reg[p] <= `PORT_RST;
         else if (wr_reg && widx_reg == idx_t'(p + 1))
         begin
            if (ctrl_reg[p])
               pat_reg[p] <= bcd_to_bin(hwdata[`BCD_W-1:0]);
            else
               pat_reg[p] <= hwdata[`PORT_W-1:0];
         end
      end

      assign dio_out[p] = pat_reg[p];
      assign dio_oe[p]  = {`PORT_W{dir_reg[p]}};
   end

   // direction: a pattern write turns the port round; the direction
   // register lets software hand the pins back to the outside world
   // limitation: a turned port stays an output until that register is written
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         dir_reg <= `DIR_RST;
      else
      begin
         if (wr_reg && widx_reg == `IDX_DIR)
            dir_reg <= hwdata[1:0];
         else if (wr_reg && widx_reg == `IDX_PORT0)
            dir_reg[0] <= 1'b1;
         else if (wr_reg && widx_reg == `IDX_PORT1)
            dir_reg[1] <= 1'b1;
      end
   end

   // ==================================================================
   // setpoint channels
   // codes are two's complement, so zero volts is the all-zero code
   for (genvar d = 0; d < 2; d++)
   begin : g_dac
      // a reset command wins over nothing else: both cannot share a cycle
      always_ff @(posedge clk or negedge rst_b)
      begin
         if (!rst_b)
            dac_reg[d] <= `DAC_ZERO;
         else if (wr_reg && widx_reg == idx_t'(d + 4))
            dac_reg[d] <= hwdata[`DAC_W-1:0];
         else if (rst_cmd && rst_chan == `CHAN_W'(d + 4))
            dac_reg[d] <= `DAC_ZERO;
      end
   end

   assign dac0_code = dac_reg[0];
   assign dac1_code = dac_reg[1];

   // ==================================================================
   // totalizer control
   // clear on a manual reset, or on a counter read in read-and-reset mode
   // the clear is not flopped: it lands on the edge that captures the count,
   // so an edge between capture and clear cannot be lost, and a read placed
   // right after a manual reset still sees the count from before the clear
   assign clr_now = (scan_count_read_step & ctrl_reg[`CTRL_MODE])
                    | (rst_cmd & (rst_chan == `CHAN_W'(`IDX_COUNT)));

   assign cnt.clr = clr_now;

   // the count core; see pulse_counter for the edge and wrap logic
   pulse_counter u_count (
      .clk      (clk),
      .rst_b    (rst_b),
      .pulse_in (pulse_in),
      .cnt      (cnt.counter)
   );

   // ==================================================================
   // read mux, sampled once at the address phase edge
   // the count is captured only here, so nothing changes without a read
   // unmapped words read zero rather than erroring, so a stray probe is harmless
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (aidx)
         `IDX_CTRL  : rd_mux = {28'h0000000, ctrl_reg};
         `IDX_PORT0 : rd_mux = ctrl_reg[`CTRL_BASE0]
                               ? {20'h00000, bin_to_bcd(pin_reg[0])}
                               : {24'h000000, pin_reg[0]};
         `IDX_PORT1 : rd_mux = ctrl_reg[`CTRL_BASE1]
                               ? {20'h00000, bin_to_bcd(pin_reg[1])}
                               : {24'h000000, pin_reg[1]};
         `IDX_COUNT : rd_mux = {6'h00, cnt.count};
         `IDX_DAC0  : rd_mux = {16'h0000, dac_reg[0]};
         `IDX_DAC1  : rd_mux = {16'h0000, dac_reg[1]};
         `IDX_DIR   : rd_mux = {30'h0, dir_reg};
         default    : rd_mux = 32'h0000_0000;           // unmapped reads zero
      endcase
   end

   // hold the last read value between reads
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         rdata_reg <= 32'h0000_0000;
      else if (addr_ok && !hwrite)
         rdata_reg <= rd_mux;
   end

   assign hrdata    = rdata_reg;
   assign hreadyout = ready_reg;
   assign hresp     = 1'b0;

   // ==================================================================
   // checks
   // the bus checks below rely on the slave never inserting wait states
   port_write_a : assert property (@(posedge clk) disable iff (!rst_b)
      wr_reg && widx_reg == `IDX_PORT0 && !ctrl_reg[`CTRL_BASE0]
      |=> pat_reg[0] == $past(hwdata[7:0]) && dio_oe[0] == 8'hff)
      else $error("port pattern not latched or not driven");

   port_turn_a : assert property (@(posedge clk) disable iff (!rst_b)
      wr_reg && widx_reg == `IDX_PORT1 |=> dir_reg[1] ##1 dir_reg[1] || wr_reg)
      else $error("port did not turn to output");

   dec_read_a : assert property (@(posedge clk) disable iff (!rst_b)
      addr_ok && !hwrite && aidx == `IDX_PORT0 && ctrl_reg[`CTRL_BASE0]
      |=> hrdata == {20'h00000, bin_to_bcd($past(pin_reg[0]))})
      else $error("decimal port read wrong");

   count_read_a : assert property (@(posedge clk) disable iff (!rst_b)
      scan_count_read_step |=> hrdata == {6'h00, $past(cnt.count)})
      else $error("count read not sampled at the request");

   count_reset_a : assert property (@(posedge clk) disable iff (!rst_b)
      scan_count_read_step && ctrl_reg[`CTRL_MODE]
      |=> cnt.count <= 26'h0000001)
      else $error("read-and-reset left the count");

   count_keep_a : assert property (@(posedge clk) disable iff (!rst_b)
      scan_count_read_step && !ctrl_reg[`CTRL_MODE] && !rst_cmd
      |=> cnt.count == $past(cnt.count) || cnt.count == $past(cnt.count) + 26'h0000001)
      else $error("continuous mode read cleared the count");

   dac_zero_a : assert property (@(posedge clk) disable iff (!rst_b)
      rst_cmd && rst_chan == 3'h4 && !(wr_reg && widx_reg == `IDX_DAC0)
      |=> dac0_code == `DAC_ZERO)
      else $error("setpoint reset did not load zero");

   dac_write_a : assert property (@(posedge clk) disable iff (!rst_b)
      wr_reg && widx_reg == `IDX_DAC1 |=> dac1_code == $past(hwdata[15:0]))
      else $error("setpoint not written");

   // the ready flop needs one edge after release, so that edge is spared
   bus_ok_a : assert property (@(posedge clk) disable iff (!rst_b)
      $past(rst_b) |-> hreadyout && !hresp)
      else $error("slave stalled or errored");

   ctrl_write_a : assert property (@(posedge clk) disable iff (!rst_b)
      wr_reg && widx_reg == `IDX_CTRL |=> ctrl_reg == $past(hwdata[`CTRL_W-1:0]))
      else $error("control write not taken");

   // a manual clear keeps at most the one edge that met it
   count_manual_a : assert property (@(posedge clk) disable iff (!rst_b)
      rst_cmd && rst_chan == `CHAN_W'(`IDX_COUNT) |=> cnt.count <= 26'h0000001)
      else $error("manual clear left a count");

   port_live_a : assert property (@(posedge clk) disable iff (!rst_b)
      addr_ok && !hwrite && aidx == `IDX_PORT1 && !ctrl_reg[`CTRL_BASE1]
      |=> hrdata == {24'h000000, $past(pin_reg[1])})
      else $error("binary port read not live");

   // between reads the answer must not move on its own
   read_hold_a : assert property (@(posedge clk) disable iff (!rst_b)
      !(addr_ok && !hwrite) |=> $stable(hrdata))
      else $error("read data changed without a read");

   dir_set_a : assert property (@(posedge clk) disable iff (!rst_b)
      wr_reg && widx_reg == `IDX_PORT0 |=> dio_oe[0] == 8'hff)
      else $error("first port did not turn to output");
endmodule

`default_nettype wire

// *** tb/dio_far_side.sv ***
// Purpose : far side of the i/o block, external pin sources and a pulse source
// Assumes : a pin the block does not drive follows the external pattern
// Notes   : the pulse line idles at rest_lvl; half period in clocks, at least 3
`timescale 1ns/100ps
`default_nettype none

module dio_far_side
   import dio_pkg::*;
(
   input  wire logic            clk,
   input  wire logic [1:0][7:0] ext_pat,   // what the outside drives on each pin
   input  wire logic [1:0][7:0] dio_out,   // block's latched pattern
   input  wire logic [1:0][7:0] dio_oe,    // block's drive enables
   input  wire logic            rest_lvl,  // idle level of the pulse line
   input  wire logic            go,        // start a burst of pulses
   input  wire logic [7:0]      n_pulses,  // pulses in the burst
   input  wire logic [11:0]     half_cyc,  // clocks per half pulse
   output logic      [1:0][7:0] dio_in,    // resolved pin levels
   output var logic             pulse_in,  // pulse line to the block
   output var logic             busy       // burst in progress
);
   // ==================================================================
   // pins
   // the block wins where it drives; elsewhere the outside source sets the level
   assign dio_in = (dio_oe & dio_out) | (~dio_oe & ext_pat);

   // ==================================================================
   // pulse source
   // each pulse leaves rest level and comes back, so edge select shows
   initial
   begin
      pulse_in = 1'b0;
      busy     = 1'b0;
      forever
      begin
         @(posedge clk);
         if (go && !busy)
         begin
            busy <= 1'b1;
            repeat (n_pulses)
            begin
               repeat (half_cyc) @(posedge clk);
               pulse_in <= ~rest_lvl;
               repeat (half_cyc) @(posedge clk);
               pulse_in <= rest_lvl;
            end
            repeat (half_cyc) @(posedge clk);
            busy <= 1'b0;
         end
         else
         begin
            // between bursts the line simply sits at rest level
            pulse_in <= rest_lvl;
         end
      end
   end
endmodule

`default_nettype wire

// *** tb/dio_totalizer_tb.sv ***
// Purpose : self-checking bench for the i/o ports, totalizer and setpoints
// Assumes : zero wait state bus slave, one 125 MHz clock
// Notes   : pin reads lag by up to 3 clocks, so the bench waits 4 before reading
`timescale 1ns/100ps
`default_nettype none
`include "dio_params.svh"

module dio_totalizer_tb
   import dio_pkg::*;
;
   // ==================================================================
   // constants
   localparam logic [31:0] A_CTRL  = {24'h0, `IDX_CTRL, 2'b00};
   localparam logic [31:0] A_PORT0 = {24'h0, `IDX_PORT0, 2'b00};
   localparam logic [31:0] A_PORT1 = {24'h0, `IDX_PORT1, 2'b00};
   localparam logic [31:0] A_COUNT = {24'h0, `IDX_COUNT, 2'b00};
   localparam logic [31:0] A_DAC0  = {24'h0, `IDX_DAC0, 2'b00};
   localparam logic [31:0] A_DAC1  = {24'h0, `IDX_DAC1, 2'b00};
   localparam logic [31:0] A_RESET = {24'h0, `IDX_RESET, 2'b00};
   localparam logic [31:0] A_DIR   = {24'h0, `IDX_DIR, 2'b00};
   localparam logic [31:0] A_HOLE  = 32'h0000_0020;   // unmapped word
   localparam logic [11:0] RATE_HALF = 12'd625;       // 100 kHz at 125 MHz
   localparam int          LIMIT     = 20000;         // whole run needs ~3400

   // ==================================================================
   // signals
   logic            clk;
   logic            rst_b;
   logic            hsel;
   logic [31:0]     haddr;
   logic [1:0]      htrans;
   logic            hwrite;
   logic [2:0]      hsize;
   logic [31:0]     hwdata;
   logic [31:0]     hrdata;
   logic            hreadyout;
   logic            hresp;
   logic [1:0][7:0] dio_in;
   logic [1:0][7:0] dio_out;
   logic [1:0][7:0] dio_oe;
   logic            pulse_in;
   logic [15:0]     dac0_code;
   logic [15:0]     dac1_code;
   logic [1:0][7:0] ext_pat;
   logic            rest_lvl;
   logic            go;
   logic [7:0]      n_pulses;
   logic [11:0]     half_cyc;
   logic            busy;
   int              cycles;
   int              mismatches;
   int              n_compared;

   dio_totalizer i_dio_totalizer (
      .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dio_in(dio_in),
      .dio_out(dio_out), .dio_oe(dio_oe), .pulse_in(pulse_in),
      .dac0_code(dac0_code), .dac1_code(dac1_code));

   dio_far_side i_dio_far_side (
      .clk(clk), .ext_pat(ext_pat), .dio_out(dio_out), .dio_oe(dio_oe),
      .rest_lvl(rest_lvl), .go(go), .n_pulses(n_pulses), .half_cyc(half_cyc),
      .dio_in(dio_in), .pulse_in(pulse_in), .busy(busy));

   // ==================================================================
   // clock and watchdog
   always #4 clk = ~clk;

   // a hang anywhere ends in the same closing report
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         mismatches++;
         $display("watchdog ran out at cycle %0d", cycles);
         complete_run();
      end
   end

   // ==================================================================
   // tasks
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one single transfer; every signal held until hready is seen high
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
      #1;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] junk;
      xfer(1'b1, a, d, junk);
   endtask

   task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] v;
      xfer(1'b0, a, 32'h0, v);
      check(nm, v, exp);
   endtask

   // let pin changes pass the input synchronisers
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask

   task automatic pulses(input logic [7:0] n, input logic [11:0] h);
      n_pulses <= n;
      half_cyc <= h;
      go       <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy === 1'b1) @(posedge clk);
      settle();
   endtask

   // ==================================================================
   // test sequence
   initial
   begin
      clk = 1'b0; rst_b = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
      hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; ext_pat = 16'h3ca5;
      rest_lvl = 1'b0; go = 1'b0; n_pulses = 8'h0; half_cyc = 12'h4;
      cycles = 0; mismatches = 0; n_compared = 0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      // state after reset: ports are inputs and show live pins
      check("oe", {16'h0, dio_oe}, 32'h0);
      check("dac0", {16'h0, dac0_code}, {16'h0, `DAC_ZERO});
      check("hresp", {31'h0, hresp}, 32'h0);
      rd_chk("ctrl", A_CTRL, {28'h0, `CTRL_RST});
      rd_chk("port0", A_PORT0, 32'h0000_00a5);
      rd_chk("port1", A_PORT1, 32'h0000_003c);
      rd_chk("count", A_COUNT, 32'h0);
      rd_chk("hole", A_HOLE, 32'h0);
      // counting runs with no enable; a burst at the full rate loses nothing
      pulses(8'd5, 12'd4);
      rd_chk("count", A_COUNT, 32'd5);
      pulses(8'd2, RATE_HALF);
      rd_chk("count", A_COUNT, 32'd7);
      wr(A_COUNT, 32'h0);
      rd_chk("count", A_COUNT, 32'd7);
      wr(A_RESET, 32'h3);
      rd_chk("count", A_COUNT, 32'h0);
      // read-and-reset mode
      wr(A_CTRL, 32'h4);
      pulses(8'd3, 12'd4);
      rd_chk("count", A_COUNT, 32'd3);
      rd_chk("count", A_COUNT, 32'h0);
      // falling edges only, continuous
      wr(A_CTRL, 32'h8);
      rest_lvl <= 1'b1;
      settle();
      rd_chk("count", A_COUNT, 32'h0);
      pulses(8'd2, 12'd4);
      rd_chk("count", A_COUNT, 32'd2);
      rest_lvl <= 1'b0;
      settle();
      rd_chk("count", A_COUNT, 32'd3);
      // output patterns latch and hold against the outside source
      wr(A_PORT0, 32'h5a);
      check("out", {16'h0, dio_out[0], dio_oe[0]}, 32'h0000_5aff);
      ext_pat <= 16'hffff;
      settle();
      rd_chk("port0", A_PORT0, 32'h5a);
      rd_chk("port1", A_PORT1, 32'hff);
      wr(A_PORT1, 32'hc3);
      check("out", {dio_out, dio_oe}, 32'hc35a_ffff);
      rd_chk("dir", A_DIR, 32'h3);
      // decimal base on one port, then on both
      wr(A_CTRL, 32'h1);
      wr(A_PORT0, 32'h240);
      check("out", {16'h0, dio_out}, 32'h0000_c3f0);
      settle();
      rd_chk("port0", A_PORT0, 32'h240);
      rd_chk("port1", A_PORT1, 32'hc3);
      wr(A_CTRL, 32'h3);
      rd_chk("port1", A_PORT1, 32'h195);
      wr(A_DIR, 32'h0);
      check("oe", {16'h0, dio_oe}, 32'h0);
      settle();
      rd_chk("port0", A_PORT0, 32'h255);
      // setpoints and their zero requests
      wr(A_DAC0, 32'h8000);
      wr(A_DAC1, 32'h7fff);
      check("dacs", {dac0_code, dac1_code}, 32'h8000_7fff);
      rd_chk("dac1", A_DAC1, 32'h7fff);
      wr(A_RESET, 32'h1);
      check("dacs", {dac0_code, dac1_code}, 32'h8000_7fff);
      wr(A_RESET, 32'h4);
      check("dacs", {dac0_code, dac1_code}, {`DAC_ZERO, 16'h7fff});
      wr(A_RESET, 32'h5);
      check("dacs", {dac0_code, dac1_code}, {`DAC_ZERO, `DAC_ZERO});
      rd_chk("reset", A_RESET, 32'h0);
      wr(A_HOLE, 32'hffff_ffff);
      rd_chk("hole", A_HOLE, 32'h0);
      complete_run();
   end
endmodule

`default_nettype wire
